/* include/smsw_pkg.sv */
package smsw_pkg;

    // status word field positions
    localparam int SW_REQ_A1 = 0;
    localparam int SW_REQ_A2 = 1;
    localparam int SW_REQ_B1 = 2;
    localparam int SW_REQ_B2 = 3;
    localparam int SW_EDM_A = 4;
    localparam int SW_EDM_B = 5;
    localparam int SW_MON = 8;
    localparam int SW_SAFE = 9;
    localparam int SW_CUTOFF = 10;
    localparam int SW_ACTIVE = 16;

    localparam int SPEED_W = 32;
    localparam int POS_W = 32;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [SPEED_W-1:0] SPEED_RESET = 32'h0000_0000;
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
    localparam logic [15:0] SLOT_SEL_SAFETY = 16'h003C;
    localparam logic [31:0] SLOT_EMPTY = 32'h0000_0000;

    // per-function safety state
    typedef enum logic [1:0] {
        SMSW_STANDBY,
        SMSW_MONITORING,
        SMSW_SAFE_ST,
        SMSW_CUTOFF_ST
    } smsw_fstate_t;

    typedef struct packed {
        logic req_a1;
        logic req_a2;
        logic req_b1;
        logic req_b2;
        logic edm_a;
        logic edm_b;
    } smsw_inputs_t;

    typedef struct packed {
        logic monitoring;
        logic safe;
        logic cutoff;
    } smsw_flags_t;

    function automatic logic [SPEED_W-1:0] smsw_abs(input logic signed [SPEED_W-1:0] v);
        smsw_abs = v[SPEED_W-1] ? SPEED_W'(-v) : SPEED_W'(v);
    endfunction : smsw_abs

endpackage : smsw_pkg

/* verilog/smsw_fn_flags.sv */
module smsw_fn_flags
    import smsw_pkg::*;
(
    // function states
    input wire smsw_fstate_t i_state_a,
    input wire smsw_fstate_t i_state_b,
    // combined flags
    output smsw_flags_t o_flags
);

    always_comb
    begin
        // a function stops showing monitoring while the other one cuts power
        o_flags.monitoring = (((i_state_a == SMSW_MONITORING) || (i_state_a == SMSW_SAFE_ST)) &&
                              (i_state_b != SMSW_CUTOFF_ST)) ||
                             (((i_state_b == SMSW_MONITORING) || (i_state_b == SMSW_SAFE_ST)) &&
                              (i_state_a != SMSW_CUTOFF_ST));
        // a monitoring function already counts as safe once the other one cuts power
        o_flags.safe = ((i_state_a == SMSW_SAFE_ST) || (i_state_a == SMSW_CUTOFF_ST) ||
                        ((i_state_a == SMSW_MONITORING) && (i_state_b == SMSW_CUTOFF_ST))) &&
                       ((i_state_b == SMSW_SAFE_ST) || (i_state_b == SMSW_CUTOFF_ST) ||
                        ((i_state_b == SMSW_MONITORING) && (i_state_a == SMSW_CUTOFF_ST)));
        o_flags.cutoff = (i_state_a == SMSW_CUTOFF_ST) || (i_state_b == SMSW_CUTOFF_ST);
    end

endmodule : smsw_fn_flags

/* verilog/smsw_pos_count.sv */
module smsw_pos_count
    import smsw_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // encoder and enable
    input wire logic i_enc_a,
    input wire logic i_enc_b,
    input wire logic i_enable,
    // count
    output logic [POS_W-1:0] o_count
);

    logic a_r;
    logic b_r;
    logic [POS_W-1:0] count_r;

    // an edge of one phase alone counts, a cycle where both phases change counts nothing: four counts per encoder pulse
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            a_r <= 1'b0;
            b_r <= 1'b0;
            count_r <= POS_RESET;
        end
        else
        begin
            a_r <= i_enc_a;
            b_r <= i_enc_b;
            if (i_enable && ((a_r ^ i_enc_a) || (b_r ^ i_enc_b)))
            begin
                if ((a_r ^ b_r ^ i_enc_a ^ i_enc_b) && ((i_enc_a ^ b_r) == 1'b1))
                    count_r <= count_r + POS_W'(1);
                else if (a_r ^ b_r ^ i_enc_a ^ i_enc_b)
                    count_r <= count_r - POS_W'(1);
            end
        end
    end

    assign o_count = count_r;

endmodule : smsw_pos_count

/* verilog/smsw_top.sv */
// Operation
// - show active-mode internal speed reference
// - reference view zero after reset
// - detected speed reported as magnitude
// - per-function monitoring speed as magnitude
// - accumulate position while position monitor active
// - position counts four edges per pulse
// - slot-one select 003C gives status word
// - slot-two select 003C gives status word
// - bits 0-3 are request inputs
// - bits 4-5 are device monitor inputs
// - bit 8 deceleration monitoring in progress
// - bit 9 safe state reached
// - bit 10 power cutoff operating
// - bit 16 active mode operating
// - same layout for both fieldbus generations
// - cutoff is either-function OR; monitoring is either-function OR, each masked while the other cuts power
// - safe bit needs both functions safe or cut off; a monitoring one counts as safe while the other cuts power
module smsw_top
    import smsw_pkg::*;
(
    // clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    // safety inputs
    input wire smsw_inputs_t I_INPUTS,
    input wire smsw_fstate_t I_STATE_A,
    input wire smsw_fstate_t I_STATE_B,
    input wire logic I_ACTIVE_MODE,
    input wire logic I_DECEL_POSITION_MONITOR,
    // speed sources
    input wire logic I_REF_VALID,
    input wire logic signed [SPEED_W-1:0] I_ACTIVE_DECEL_SPEED_REF,
    input wire logic signed [SPEED_W-1:0] I_DETECTED_SPEED,
    input wire logic signed [SPEED_W-1:0] I_MONITOR_SPEED_A,
    input wire logic signed [SPEED_W-1:0] I_MONITOR_SPEED_B,
    // encoder
    input wire logic I_ENC_A,
    input wire logic I_ENC_B,
    // slot selection
    input wire logic [15:0] I_OPTION_SLOT_ONE_SELECT,
    input wire logic [15:0] I_OPTION_SLOT_TWO_SELECT,
    // monitor views
    output logic [SPEED_W-1:0] O_ACTIVE_DECEL_SPEED_REF_VIEW,
    output logic [SPEED_W-1:0] O_DETECTED_MOTOR_SPEED_VIEW,
    output logic [POS_W-1:0] O_DETECTED_MOTOR_POSITION_VIEW,
    output logic [SPEED_W-1:0] O_MONITOR_SPEED_A_VIEW,
    output logic [SPEED_W-1:0] O_MONITOR_SPEED_B_VIEW,
    // status word and option slots
    output logic [31:0] O_SAFETY_OPTION_MONITOR_WORD,
    output logic [31:0] O_OPTION_MONITOR_1,
    output logic [31:0] O_OPTION_MONITOR_2
);

    smsw_flags_t flags;
    logic [31:0] word_nxt;
    logic [31:0] word_r;
    logic [SPEED_W-1:0] ref_r;
    logic [SPEED_W-1:0] spd_r;
    logic [SPEED_W-1:0] mon_a_r;
    logic [SPEED_W-1:0] mon_b_r;
    logic [31:0] slot1_r;
    logic [31:0] slot2_r;

    ////////////////////////////////////////////////////////////////////////////
    smsw_fn_flags u_flags (
        .i_state_a(I_STATE_A),
        .i_state_b(I_STATE_B),
        .o_flags(flags)
    );

    smsw_pos_count u_pos (
        .i_clk(I_REF_CLK),
        .i_reset_n(I_RESET_N),
        .i_enc_a(I_ENC_A),
        .i_enc_b(I_ENC_B),
        .i_enable(I_DECEL_POSITION_MONITOR),
        .o_count(O_DETECTED_MOTOR_POSITION_VIEW)
    );

    ////////////////////////////////////////////////////////////////////////////
    // word is built whole each cycle, so reserved bits can never latch
    always_comb
    begin
        word_nxt = WORD_RESET;
        word_nxt[SW_REQ_A1] = I_INPUTS.req_a1;
        word_nxt[SW_REQ_A2] = I_INPUTS.req_a2;
        word_nxt[SW_REQ_B1] = I_INPUTS.req_b1;
        word_nxt[SW_REQ_B2] = I_INPUTS.req_b2;
        word_nxt[SW_EDM_A] = I_INPUTS.edm_a;
        word_nxt[SW_EDM_B] = I_INPUTS.edm_b;
        word_nxt[SW_MON] = flags.monitoring;
        word_nxt[SW_SAFE] = flags.safe;
        word_nxt[SW_CUTOFF] = flags.cutoff;
        word_nxt[SW_ACTIVE] = I_ACTIVE_MODE;
    end

    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RESET_N)
            word_r <= WORD_RESET;
        else
            word_r <= word_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference holds its last value until a new one is generated
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RESET_N)
            ref_r <= SPEED_RESET;
        else if (I_REF_VALID)
            ref_r <= I_ACTIVE_DECEL_SPEED_REF;
    end

    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RESET_N)
        begin
            spd_r <= SPEED_RESET;
            mon_a_r <= SPEED_RESET;
            mon_b_r <= SPEED_RESET;
        end
        else
        begin
            spd_r <= smsw_abs(I_DETECTED_SPEED);
            mon_a_r <= (I_STATE_A != SMSW_STANDBY) ? smsw_abs(I_MONITOR_SPEED_A) : SPEED_RESET;
            mon_b_r <= (I_STATE_B != SMSW_STANDBY) ? smsw_abs(I_MONITOR_SPEED_B) : SPEED_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one slot mux serves both fieldbus generations; the host picks the slot
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RESET_N)
        begin
            slot1_r <= SLOT_EMPTY;
            slot2_r <= SLOT_EMPTY;
        end
        else
        begin
            slot1_r <= (I_OPTION_SLOT_ONE_SELECT == SLOT_SEL_SAFETY) ? word_nxt : SLOT_EMPTY;
            slot2_r <= (I_OPTION_SLOT_TWO_SELECT == SLOT_SEL_SAFETY) ? word_nxt : SLOT_EMPTY;
        end
    end

    assign O_ACTIVE_DECEL_SPEED_REF_VIEW = ref_r;
    assign O_DETECTED_MOTOR_SPEED_VIEW = spd_r;
    assign O_MONITOR_SPEED_A_VIEW = mon_a_r;
    assign O_MONITOR_SPEED_B_VIEW = mon_b_r;
    assign O_SAFETY_OPTION_MONITOR_WORD = word_r;
    assign O_OPTION_MONITOR_1 = slot1_r;
    assign O_OPTION_MONITOR_2 = slot2_r;

    ////////////////////////////////////////////////////////////////////////////
    property p_reserved_zero;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (word_r & 32'hFFFE_F8C0) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved status bits not zero");

    property p_req_bits;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        1'b1 |=> word_r[3:0] == {$past(I_INPUTS.req_b2), $past(I_INPUTS.req_b1),
                                 $past(I_INPUTS.req_a2), $past(I_INPUTS.req_a1)};
    endproperty
    a_req_bits: assert property (p_req_bits)
        else $error("request bits wrong");

    property p_edm_bits;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        1'b1 |=> word_r[5:4] == {$past(I_INPUTS.edm_b), $past(I_INPUTS.edm_a)};
    endproperty
    a_edm_bits: assert property (p_edm_bits)
        else $error("device monitor bits wrong");

    property p_safe_both;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (I_STATE_A == SMSW_STANDBY || I_STATE_B == SMSW_STANDBY) |=> !word_r[SW_SAFE];
    endproperty
    a_safe_both: assert property (p_safe_both)
        else $error("safe bit set with a function on standby");

    property p_cutoff_either;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (I_STATE_A == SMSW_CUTOFF_ST || I_STATE_B == SMSW_CUTOFF_ST) |=> word_r[SW_CUTOFF];
    endproperty
    a_cutoff_either: assert property (p_cutoff_either)
        else $error("cutoff bit missing");

    property p_mon_either;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        ((I_STATE_A == SMSW_MONITORING) && (I_STATE_B != SMSW_CUTOFF_ST)) ||
        ((I_STATE_B == SMSW_MONITORING) && (I_STATE_A != SMSW_CUTOFF_ST)) |=> word_r[SW_MON];
    endproperty
    a_mon_either: assert property (p_mon_either)
        else $error("monitoring bit missing");

    property p_active_bit;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        1'b1 |=> word_r[SW_ACTIVE] == $past(I_ACTIVE_MODE);
    endproperty
    a_active_bit: assert property (p_active_bit)
        else $error("active mode bit wrong");

    property p_slot_one;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (I_OPTION_SLOT_ONE_SELECT == SLOT_SEL_SAFETY) |=> ##0 O_OPTION_MONITOR_1 == word_r;
    endproperty
    a_slot_one: assert property (p_slot_one)
        else $error("slot one not carrying status word");

    property p_slot_two;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (I_OPTION_SLOT_TWO_SELECT != SLOT_SEL_SAFETY) |=> O_OPTION_MONITOR_2 == SLOT_EMPTY;
    endproperty
    a_slot_two: assert property (p_slot_two)
        else $error("slot two not empty when unselected");

    property p_speed_abs;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        1'b1 |=> !O_DETECTED_MOTOR_SPEED_VIEW[SPEED_W-1] || $past(I_DETECTED_SPEED) == 32'sh8000_0000;
    endproperty
    a_speed_abs: assert property (p_speed_abs)
        else $error("speed view negative");

    property p_ref_hold;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (!I_REF_VALID && $past(I_RESET_N)) |=> $stable(O_ACTIVE_DECEL_SPEED_REF_VIEW);
    endproperty
    a_ref_hold: assert property (p_ref_hold)
        else $error("reference view changed without new reference");

    property p_pos_hold;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (!I_DECEL_POSITION_MONITOR && $past(I_RESET_N)) |=> $stable(O_DETECTED_MOTOR_POSITION_VIEW);
    endproperty
    a_pos_hold: assert property (p_pos_hold)
        else $error("position moved while monitor off");

    property p_ref_load;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        I_REF_VALID |=> O_ACTIVE_DECEL_SPEED_REF_VIEW == $past(I_ACTIVE_DECEL_SPEED_REF);
    endproperty
    a_ref_load: assert property (p_ref_load)
        else $error("reference view not loaded");

    // no disable here: this one has to look through reset
    property p_ref_reset;
        @(posedge I_REF_CLK)
        !I_RESET_N |=> O_ACTIVE_DECEL_SPEED_REF_VIEW == SPEED_RESET;
    endproperty
    a_ref_reset: assert property (p_ref_reset)
        else $error("reference view not zero after reset");

    property p_speed_mag;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        1'b1 |=> (O_DETECTED_MOTOR_SPEED_VIEW == $past(I_DETECTED_SPEED)) ||
                 (O_DETECTED_MOTOR_SPEED_VIEW == SPEED_W'(-$past(I_DETECTED_SPEED)));
    endproperty
    a_speed_mag: assert property (p_speed_mag)
        else $error("speed view not the magnitude");

    property p_mon_a_mag;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (I_STATE_A != SMSW_STANDBY) |=> (O_MONITOR_SPEED_A_VIEW == $past(I_MONITOR_SPEED_A)) ||
                                       (O_MONITOR_SPEED_A_VIEW == SPEED_W'(-$past(I_MONITOR_SPEED_A)));
    endproperty
    a_mon_a_mag: assert property (p_mon_a_mag)
        else $error("monitor speed a not the magnitude");

    property p_mon_b_mag;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (I_STATE_B != SMSW_STANDBY) |=> (O_MONITOR_SPEED_B_VIEW == $past(I_MONITOR_SPEED_B)) ||
                                       (O_MONITOR_SPEED_B_VIEW == SPEED_W'(-$past(I_MONITOR_SPEED_B)));
    endproperty
    a_mon_b_mag: assert property (p_mon_b_mag)
        else $error("monitor speed b not the magnitude");

    property p_mon_a_idle;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (I_STATE_A == SMSW_STANDBY) |=> O_MONITOR_SPEED_A_VIEW == SPEED_RESET;
    endproperty
    a_mon_a_idle: assert property (p_mon_a_idle)
        else $error("monitor speed a not zero on standby");

    property p_mon_b_idle;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (I_STATE_B == SMSW_STANDBY) |=> O_MONITOR_SPEED_B_VIEW == SPEED_RESET;
    endproperty
    a_mon_b_idle: assert property (p_mon_b_idle)
        else $error("monitor speed b not zero on standby");

    property p_slot_one_off;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (I_OPTION_SLOT_ONE_SELECT != SLOT_SEL_SAFETY) |=> O_OPTION_MONITOR_1 == SLOT_EMPTY;
    endproperty
    a_slot_one_off: assert property (p_slot_one_off)
        else $error("slot one not empty when unselected");

    property p_slot_two_on;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (I_OPTION_SLOT_TWO_SELECT == SLOT_SEL_SAFETY) |=> O_OPTION_MONITOR_2 == word_r;
    endproperty
    a_slot_two_on: assert property (p_slot_two_on)
        else $error("slot two not carrying status word");

    property p_safe_set;
        @(posedge I_REF_CLK) disable iff (!I_RESET_N)
        ((I_STATE_A == SMSW_SAFE_ST) || (I_STATE_A == SMSW_CUTOFF_ST)) &&
        ((I_STATE_B == SMSW_SAFE_ST) || (I_STATE_B == SMSW_CUTOFF_ST)) |=> word_r[SW_SAFE];
    endproperty
    a_safe_set: assert property (p_safe_set)
        else $error("safe bit missing with both functions safe");

endmodule : smsw_top

/* dv/smsw_host_model.sv */
module smsw_host_model
    import smsw_pkg::*;
#(
    parameter logic [15:0] OTHER_SEL = 16'h0001
)
(
    // clock
    input wire logic i_clk,
    // slot mapping wanted by the test
    input wire logic i_map_one,
    input wire logic i_map_two,
    // option monitors from the device
    input wire logic [31:0] i_slot_one,
    input wire logic [31:0] i_slot_two,
    // selection parameters and captured words
    output logic [15:0] o_slot_one_select,
    output logic [15:0] o_slot_two_select,
    output logic [31:0] o_seen_one,
    output logic [31:0] o_seen_two
);
    timeunit 1ns;
    timeprecision 1ps;

    // an unmapped slot carries a code the device must not answer
    assign o_slot_one_select = i_map_one ? SLOT_SEL_SAFETY : OTHER_SEL;
    assign o_slot_two_select = i_map_two ? SLOT_SEL_SAFETY : OTHER_SEL;

    always_ff @(posedge i_clk)
    begin
        o_seen_one <= i_slot_one;
        o_seen_two <= i_slot_two;
    end
endmodule : smsw_host_model

/* dv/tb.sv */
module tb
    import smsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    smsw_inputs_t inp = '1;
    smsw_fstate_t sa = SMSW_STANDBY;
    smsw_fstate_t sb = SMSW_STANDBY;
    logic act = 1'b1;
    logic pmon = 1'b0;
    logic rv = 1'b0;
    logic signed [31:0] ref_v = 32'h0000_0123;
    logic signed [31:0] det = -32'sd5;
    logic signed [31:0] msa = 32'h0000_0000;
    logic signed [31:0] msb = 32'h0000_0000;
    logic ea = 1'b0;
    logic eb = 1'b0;
    logic map1 = 1'b1;
    logic map2 = 1'b1;
    logic [15:0] sel1;
    logic [15:0] sel2;
    logic [31:0] v_ref, v_det, v_pos, v_ma, v_mb, word, om1, om2, seen1, seen2;
    int fails = 0;
    int checks = 0;
    localparam logic [31:0] FULL_W = 32'h0001_033F;
    // combined flags for each state pair, bit index a*4+b
    localparam logic [15:0] MON_TBL = 16'h0776;
    localparam logic [15:0] SAFE_TBL = 16'hEC80;
    localparam logic [15:0] CUT_TBL = 16'hF888;
    logic [1:0] fwd [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
    logic [1:0] rev [4] = '{2'b01, 2'b11, 2'b10, 2'b00};

    always #2 clk = ~clk;

    smsw_top dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_INPUTS(inp), .I_STATE_A(sa), .I_STATE_B(sb),
        .I_ACTIVE_MODE(act), .I_DECEL_POSITION_MONITOR(pmon), .I_REF_VALID(rv), .I_ACTIVE_DECEL_SPEED_REF(ref_v),
        .I_DETECTED_SPEED(det), .I_MONITOR_SPEED_A(msa), .I_MONITOR_SPEED_B(msb), .I_ENC_A(ea), .I_ENC_B(eb),
        .I_OPTION_SLOT_ONE_SELECT(sel1), .I_OPTION_SLOT_TWO_SELECT(sel2), .O_ACTIVE_DECEL_SPEED_REF_VIEW(v_ref),
        .O_DETECTED_MOTOR_SPEED_VIEW(v_det), .O_DETECTED_MOTOR_POSITION_VIEW(v_pos), .O_MONITOR_SPEED_A_VIEW(v_ma),
        .O_MONITOR_SPEED_B_VIEW(v_mb), .O_SAFETY_OPTION_MONITOR_WORD(word), .O_OPTION_MONITOR_1(om1),
        .O_OPTION_MONITOR_2(om2));

    smsw_host_model host (.i_clk(clk), .i_map_one(map1), .i_map_two(map2), .i_slot_one(om1), .i_slot_two(om2),
        .o_slot_one_select(sel1), .o_slot_two_select(sel2), .o_seen_one(seen1), .o_seen_two(seen2));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // let the sampling edge pass, then look once its updates landed
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic enc(input logic [1:0] ab);
        @(posedge clk);
        ea <= ab[1];
        eb <= ab[0];
    endtask : enc

    task automatic stop_test();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        // live inputs during reset must not leak out
        chk(word | om1 | om2 | v_det | v_pos | v_ma | v_mb, 32'h0000_0000);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) step();
        chk(v_ref, 32'h0000_0000);
        chk(v_det, 32'h0000_0005);
        @(posedge clk);
        rv <= 1'b1;
        ref_v <= -32'sd100;
        det <= 32'sd5;
        step();
        chk(v_ref, 32'hFFFF_FF9C);
        chk(v_det, 32'h0000_0005);
        @(posedge clk);
        rv <= 1'b0;
        ref_v <= 32'sd77;
        repeat (2) step();
        chk(v_ref, 32'hFFFF_FF9C);
        // per-function monitoring speeds, standby reads zero
        @(posedge clk);
        msa <= -32'sd7;
        msb <= 32'sd9;
        sa <= SMSW_MONITORING;
        sb <= SMSW_SAFE_ST;
        step();
        chk(v_ma, 32'h0000_0007);
        chk(v_mb, 32'h0000_0009);
        @(posedge clk);
        sa <= SMSW_STANDBY;
        step();
        chk(v_ma, 32'h0000_0000);
        // full word, every slot mapping
        // b safe alone: monitoring shows, the combined safe bit stays clear
        chk(word, 32'h0001_013F);
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk);
            sa <= SMSW_SAFE_ST;
            map1 <= m[0];
            map2 <= m[1];
            step();
            chk(word & 32'hFFFE_F8C0, 32'h0000_0000);
            chk(om1, m[0] ? FULL_W : SLOT_EMPTY);
            chk(om2, m[1] ? FULL_W : SLOT_EMPTY);
            step();
            chk(seen1, m[0] ? FULL_W : SLOT_EMPTY);
            chk(seen2, m[1] ? FULL_W : SLOT_EMPTY);
        end
        // walking one over the inputs, then active mode alone
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clk);
            sa <= SMSW_STANDBY;
            sb <= SMSW_STANDBY;
            inp <= (i < 6) ? 6'(1 << (5 - i)) : 6'h00;
            act <= (i == 6);
            step();
            chk(word, (i < 6) ? 32'(1) << i : 32'h0001_0000);
        end
        // all state pairs against the interaction table
        for (int a = 0; a < 4; a++)
            for (int b = 0; b < 4; b++)
            begin
                @(posedge clk);
                sa <= smsw_fstate_t'(a);
                sb <= smsw_fstate_t'(b);
                step();
                chk(32'(word[SW_CUTOFF]), 32'(CUT_TBL[a * 4 + b]));
                chk(32'(word[SW_MON]), 32'(MON_TBL[a * 4 + b]));
                chk(32'(word[SW_SAFE]), 32'(SAFE_TBL[a * 4 + b]));
            end
        // position: forward pulse, ignored pulse, two reverse pulses
        @(posedge clk);
        pmon <= 1'b1;
        foreach (fwd[k]) enc(fwd[k]);
        repeat (3) step();
        chk(v_pos, 32'h0000_0004);
        @(posedge clk);
        pmon <= 1'b0;
        foreach (fwd[k]) enc(fwd[k]);
        repeat (3) step();
        chk(v_pos, 32'h0000_0004);
        @(posedge clk);
        pmon <= 1'b1;
        repeat (2) foreach (rev[k]) enc(rev[k]);
        repeat (3) step();
        chk(v_pos, 32'hFFFF_FFFC);
        stop_test();
    end
endmodule : tb
